/* File: design/spi_sensor_defs.svh */
// Function
// RULE_01: Port works in clock modes 0 and 3
// RULE_02: Master frames one command per select-low period
// RULE_03: Clock idles high while select high
// RULE_04: Drive on falling edge, sample on rising
// RULE_05: Sixteen pulses, eight more per byte
// RULE_06: Bit 0 starts first falling edge after select
// RULE_07: Bit 0 zero means write
// RULE_08: Bit 0 one means read
// RULE_09: Bit 1 enables address auto-increment
// RULE_10: Bits 2-7 hold register index, MSB first
// RULE_11: Write data in bits 8-15, MSB first
// RULE_12: Read data shifted out bits 8-15
// RULE_13: Multi-byte reads on single shared line
// RULE_14: Eight-bit registers, output bytes read-only
// RULE_15: Identity register fixed and read-only
// RULE_16: Averaging register writable, resets to 1b
// RULE_17: Bits 5:3 select temperature averaging count
// RULE_18: Bits 2:0 select humidity averaging count
// RULE_19: Master never writes reserved addresses
// RULE_20: Calibration loaded at power-on, not modified; device stores writes to calibration bytes, reloads after each reset
// RULE_21: Internal register address is seven bits
// RULE_22: Data line driven only during read data
`ifndef SPI_SENSOR_DEFS_SVH
`define SPI_SENSOR_DEFS_SVH
`define ADDR_IDENTITY 7'h0f
`define ADDR_AVERAGING 7'h10
`define ADDR_CONTROL_ONE 7'h20
`define ADDR_CONTROL_TWO 7'h21
`define ADDR_CONTROL_THREE 7'h22
`define ADDR_STATUS 7'h27
`define ADDR_HUMID_LOW 7'h28
`define ADDR_HUMID_HIGH 7'h29
`define ADDR_TEMP_LOW 7'h2a
`define ADDR_TEMP_HIGH 7'h2b
`define ADDR_CALIB_BASE 7'h30
`define AVERAGING_RESET 8'h1b
`define TEMP_AVG_HI 5
`define TEMP_AVG_LO 3
`define HUMID_AVG_HI 2
`define HUMID_AVG_LO 0
`define CMD_BIT_READ 0
`define CMD_BIT_INC 1
`define HEADER_BITS 8
`define BYTE_BITS 8
`define LINK_CLOCK_HALF_NS 160
`define SYS_CLOCK_NS 40
`define LINK_HALF_CYCLES ((`LINK_CLOCK_HALF_NS + `SYS_CLOCK_NS - 1) / `SYS_CLOCK_NS)
`endif

/* File: design/spi_sensor_device.sv */
`timescale 1ns/1ps
`default_nettype none
`include "spi_sensor_defs.svh"
module spi_sensor_device #(
   parameter spi_sensor_pkg::byte_t IDENTITY_CODE = 8'h5a  // Arbitrary value
) (
   input wire logic CLK,
   input wire logic RST_N,
   spi_sensor_link.device LINK,
   input wire spi_sensor_pkg::byte_t HUMID_LOW,
   input wire spi_sensor_pkg::byte_t HUMID_HIGH,
   input wire spi_sensor_pkg::byte_t TEMP_LOW,
   input wire spi_sensor_pkg::byte_t TEMP_HIGH,
   input wire spi_sensor_pkg::byte_t MEAS_STATUS,
   input wire logic [127:0] CALIB_INIT,
   output spi_sensor_pkg::byte_t AVERAGING,
   output logic [2:0] TEMP_AVERAGE_SELECT,
   output logic [2:0] HUMID_AVERAGE_SELECT,
   output spi_sensor_pkg::byte_t CONTROL_ONE,
   output spi_sensor_pkg::byte_t CONTROL_TWO,
   output spi_sensor_pkg::byte_t CONTROL_THREE
);
   import spi_sensor_pkg::*;
   typedef struct packed {
      logic [1:0] cs_sync;
      logic [1:0] clk_sync;
      logic [1:0] din_sync;
      logic clk_prev;
      dev_phase_e phase;
      logic [2:0] bit_cnt;
      logic [7:0] shift;
      logic read_cmd;
      logic inc;
      reg_addr_t addr;
      byte_t tx;
      logic drive;
      logic data_out;
      byte_t averaging;
      byte_t control_one;
      byte_t control_two;
      byte_t control_three;
      logic calib_loaded;
      logic [15:0][7:0] calib;
   } dev_state_s;
   dev_state_s state;
   dev_state_s next_state;
   logic sel;
   logic rise;
   logic fall;
   logic [7:0] shifted;
   byte_t rd;
   logic [15:0] calib_hit;
   logic calib_sel;

   ////////////////////////////////////////////////////////////////////
   // Calibration entry decode, one compare per byte
   for (genvar g = 0; g < 16; g++) begin : g_calib_hit
      assign calib_hit[g] = (state.addr == 7'(`ADDR_CALIB_BASE + g));
   end
   assign calib_sel = |calib_hit;  // [RULE_20]

   ////////////////////////////////////////////////////////////////////
   // Read mux
   always_comb begin
      rd = 8'h00;
      if (calib_sel) begin  // [RULE_20]
         rd = state.calib[state.addr[3:0]];
      end
      case (state.addr)  // [RULE_21]
         `ADDR_IDENTITY: rd = IDENTITY_CODE;  // [RULE_15]
         `ADDR_AVERAGING: rd = state.averaging;  // [RULE_16]
         `ADDR_CONTROL_ONE: rd = state.control_one;
         `ADDR_CONTROL_TWO: rd = state.control_two;
         `ADDR_CONTROL_THREE: rd = state.control_three;
         `ADDR_STATUS: rd = MEAS_STATUS;
         `ADDR_HUMID_LOW: rd = HUMID_LOW;  // [RULE_14]
         `ADDR_HUMID_HIGH: rd = HUMID_HIGH;  // [RULE_14]
         `ADDR_TEMP_LOW: rd = TEMP_LOW;  // [RULE_14]
         `ADDR_TEMP_HIGH: rd = TEMP_HIGH;  // [RULE_14]
         default: ;
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      next_state = state;
      next_state.cs_sync = {state.cs_sync[0], LINK.select_n};
      next_state.clk_sync = {state.clk_sync[0], LINK.serial_port_clock};
      next_state.din_sync = {state.din_sync[0], LINK.shared_serial_data};
      next_state.clk_prev = state.clk_sync[1];
      sel = ~state.cs_sync[1];
      rise = state.clk_sync[1] & ~state.clk_prev;  // [RULE_01]
      fall = ~state.clk_sync[1] & state.clk_prev;
      shifted = {state.shift[6:0], state.din_sync[1]};
      if (!state.calib_loaded) begin
         next_state.calib = CALIB_INIT;  // [RULE_20]
         next_state.calib_loaded = 1'b1;
      end
      if (!sel) begin
         next_state.phase = DEV_IDLE;
         next_state.drive = 1'b0;  // [RULE_22]
         next_state.bit_cnt = 3'd0;
      end else begin
         case (state.phase)
            DEV_IDLE: begin
               next_state.phase = DEV_HEADER;
               next_state.bit_cnt = 3'd0;  // [RULE_06]
            end
            DEV_HEADER: begin
               if (rise) begin  // [RULE_04]
                  next_state.shift = shifted;
                  next_state.bit_cnt = state.bit_cnt + 3'd1;
                  if (state.bit_cnt == 3'd7) begin  // [RULE_05]
                     next_state.phase = DEV_DATA;
                     next_state.read_cmd = shifted[7 - `CMD_BIT_READ];  // [RULE_07] [RULE_08]
                     next_state.inc = shifted[7 - `CMD_BIT_INC];  // [RULE_09]
                     next_state.addr = {1'b0, shifted[5:0]};  // [RULE_10]
                  end
               end
            end
            DEV_DATA: begin
               if (fall && state.read_cmd) begin  // [RULE_04] [RULE_12]
                  if (state.bit_cnt == 3'd0) begin
                     next_state.data_out = rd[7];
                     next_state.tx = {rd[6:0], 1'b0};
                  end else begin
                     next_state.data_out = state.tx[7];
                     next_state.tx = {state.tx[6:0], 1'b0};
                  end
                  next_state.drive = 1'b1;  // [RULE_22]
               end
               if (rise) begin
                  next_state.shift = shifted;  // [RULE_11]
                  next_state.bit_cnt = state.bit_cnt + 3'd1;
                  if (state.bit_cnt == 3'd7) begin  // [RULE_05] [RULE_13]
                     if (!state.read_cmd) begin
                        case (state.addr)
                           `ADDR_AVERAGING: next_state.averaging = shifted;  // [RULE_16]
                           `ADDR_CONTROL_ONE: next_state.control_one = shifted;
                           `ADDR_CONTROL_TWO: next_state.control_two = shifted;
                           `ADDR_CONTROL_THREE: next_state.control_three = shifted;
                           default: begin
                              if (calib_sel) begin
                                 next_state.calib[state.addr[3:0]] = shifted;
                              end
                           end
                        endcase
                     end
                     if (state.inc) begin
                        next_state.addr = state.addr + 7'd1;  // [RULE_09]
                     end
                  end
               end
            end
            default: next_state.phase = DEV_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         state <= '0;
         state.cs_sync <= 2'b11;
         state.clk_sync <= 2'b11;
         state.clk_prev <= 1'b1;
         state.averaging <= `AVERAGING_RESET;  // [RULE_16]
      end else begin
         state <= next_state;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Outputs
   assign LINK.dev_data_out = state.data_out;
   assign LINK.dev_data_oe = state.drive;
   assign AVERAGING = state.averaging;
   assign TEMP_AVERAGE_SELECT = state.averaging[`TEMP_AVG_HI:`TEMP_AVG_LO];  // [RULE_17]
   assign HUMID_AVERAGE_SELECT = state.averaging[`HUMID_AVG_HI:`HUMID_AVG_LO];  // [RULE_18]
   assign CONTROL_ONE = state.control_one;
   assign CONTROL_TWO = state.control_two;
   assign CONTROL_THREE = state.control_three;
endmodule
`default_nettype wire

/* File: design/spi_sensor_host.sv */
`timescale 1ns/1ps
`default_nettype none
`include "spi_sensor_defs.svh"
module spi_sensor_host #(
   parameter int MAX_BYTES = 4,
   parameter int HALF_CYCLES = `LINK_HALF_CYCLES
) (
   input wire logic CLK,
   input wire logic RST_N,
   spi_sensor_link.host LINK,
   input wire logic START,
   input wire logic READ,
   input wire logic AUTO_INC,
   input wire logic [5:0] ADDR,
   input wire logic [2:0] BYTE_COUNT,
   input wire logic [7:0] WRITE_BYTE,
   output logic BUSY,
   output logic WRITE_TAKEN,
   output logic [7:0] READ_BYTE,
   output logic READ_VALID,
   output logic DONE
);
   import spi_sensor_pkg::*;
   typedef struct packed {
      host_phase_e phase;
      logic [7:0] div;
      logic [2:0] bit_cnt;
      logic [2:0] bytes_left;
      logic header;
      logic is_read;
      logic [7:0] tx;
      logic [7:0] rx;
      logic [1:0] din_sync;
      logic sclk;
      logic sel_n;
      logic oe;
      logic dout;
      logic [7:0] read_byte;
      logic read_valid;
      logic write_taken;
      logic done;
   } host_state_s;
   host_state_s state;
   host_state_s next_state;
   logic tick;

   ////////////////////////////////////////////////////////////////////
   // Frame sequencer
   always_comb begin
      next_state = state;
      next_state.din_sync = {state.din_sync[0], LINK.shared_serial_data};
      next_state.read_valid = 1'b0;
      next_state.write_taken = 1'b0;
      next_state.done = 1'b0;
      tick = (state.div == 8'(HALF_CYCLES - 1));
      next_state.div = tick ? 8'h00 : state.div + 8'h01;
      case (state.phase)
         HOST_IDLE: begin
            next_state.div = 8'h00;
            next_state.sclk = 1'b1;  // [RULE_03]
            next_state.sel_n = 1'b1;
            if (START && BYTE_COUNT != 3'd0) begin
               next_state.phase = HOST_SELECT;
               next_state.sel_n = 1'b0;  // [RULE_02]
               next_state.tx = {READ, AUTO_INC, ADDR};  // [RULE_07] [RULE_08] [RULE_09] [RULE_10]
               next_state.is_read = READ;
               next_state.header = 1'b1;
               next_state.bit_cnt = 3'd0;
               next_state.bytes_left = BYTE_COUNT;
            end
         end
         HOST_SELECT: begin
            if (tick) begin
               next_state.phase = HOST_LOW;
               next_state.sclk = 1'b0;  // [RULE_06]
               next_state.oe = state.header | ~state.is_read;  // [RULE_04]
               next_state.dout = state.tx[7];
            end
         end
         HOST_LOW: begin
            if (tick) begin
               next_state.phase = HOST_HIGH;
               next_state.sclk = 1'b1;
            end
         end
         HOST_HIGH: begin
            if (tick) begin
               // Sampled late in high half, past sync delay
               next_state.rx = {state.rx[6:0], state.din_sync[1]};  // [RULE_04]
               next_state.tx = {state.tx[6:0], 1'b0};
               next_state.bit_cnt = state.bit_cnt + 3'd1;
               if (state.bit_cnt == 3'd7) begin  // [RULE_05]
                  if (!state.header) begin
                     next_state.bytes_left = state.bytes_left - 3'd1;
                     if (state.is_read) begin
                        next_state.read_byte = {state.rx[6:0], state.din_sync[1]};
                        next_state.read_valid = 1'b1;
                     end
                  end
                  if (!state.header && state.bytes_left == 3'd1) begin
                     next_state.phase = HOST_DESELECT;
                     next_state.oe = 1'b0;
                  end else begin
                     next_state.header = 1'b0;
                     next_state.tx = WRITE_BYTE;  // [RULE_11]
                     next_state.write_taken = ~state.is_read;
                     next_state.phase = HOST_LOW;
                     next_state.sclk = 1'b0;
                     next_state.oe = ~state.is_read;
                     next_state.dout = WRITE_BYTE[7];
                  end
               end else begin
                  next_state.phase = HOST_LOW;
                  next_state.sclk = 1'b0;
                  next_state.dout = state.tx[6];
               end
            end
         end
         HOST_DESELECT: begin
            if (tick) begin
               next_state.phase = HOST_IDLE;
               next_state.sel_n = 1'b1;  // [RULE_02]
               next_state.done = 1'b1;
            end
         end
         default: next_state.phase = HOST_IDLE;
      endcase
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         state <= '0;
         state.sclk <= 1'b1;
         state.sel_n <= 1'b1;
         state.din_sync <= 2'b11;
      end else begin
         state <= next_state;
      end
   end

   assign LINK.select_n = state.sel_n;
   assign LINK.serial_port_clock = state.sclk;  // [RULE_01]
   assign LINK.host_data_out = state.dout;
   assign LINK.host_data_oe = state.oe;
   assign BUSY = (state.phase != HOST_IDLE);
   assign WRITE_TAKEN = state.write_taken;
   assign READ_BYTE = state.read_byte;
   assign READ_VALID = state.read_valid;
   assign DONE = state.done;
endmodule
`default_nettype wire

/* File: design/spi_sensor_link.sv */
`timescale 1ns/1ps
`default_nettype none
interface spi_sensor_link;
   logic select_n;
   logic serial_port_clock;
   logic host_data_out;
   logic host_data_oe;
   logic dev_data_out;
   logic dev_data_oe;
   logic shared_serial_data;
   assign shared_serial_data = dev_data_oe ? dev_data_out : (host_data_oe ? host_data_out : 1'b1);
   modport device (
      input select_n,
      input serial_port_clock,
      input shared_serial_data,
      output dev_data_out,
      output dev_data_oe
   );
   modport host (
      output select_n,
      output serial_port_clock,
      output host_data_out,
      output host_data_oe,
      input shared_serial_data
   );
endinterface
`default_nettype wire

/* File: design/spi_sensor_pkg.sv */
package spi_sensor_pkg;
   typedef logic [7:0] byte_t;
   typedef logic [6:0] reg_addr_t;
   typedef enum logic [1:0] {
      DEV_IDLE = 2'b00,
      DEV_HEADER = 2'b01,
      DEV_DATA = 2'b11
   } dev_phase_e;
   typedef enum logic [2:0] {
      HOST_IDLE = 3'b000,
      HOST_SELECT = 3'b001,
      HOST_LOW = 3'b011,
      HOST_HIGH = 3'b010,
      HOST_DESELECT = 3'b110
   } host_phase_e;
endpackage

/* File: tb/spi_sensor_props.sv */
`timescale 1ns/1ps
`default_nettype none
module spi_sensor_props (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic select_n,
   input wire logic serial_port_clock,
   input wire logic host_data_out,
   input wire logic host_data_oe,
   input wire logic dev_data_out,
   input wire logic dev_data_oe,
   input wire logic shared_serial_data
);
   logic clk_q;
   logic is_read;
   logic link_rise;
   logic [7:0] pulses;
   assign link_rise = serial_port_clock && !clk_q && !select_n;
   ////////////////////////////////////////////////////////////////
   // Rising link edges per frame, first bit latched
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         clk_q <= 1'b1;
         pulses <= 8'h00;
         is_read <= 1'b0;
      end else begin
         clk_q <= serial_port_clock;
         if (select_n) begin
            pulses <= 8'h00;
         end else if (link_rise) begin
            pulses <= pulses + 8'h01;
            if (pulses == 8'h00) begin
               is_read <= shared_serial_data;
            end
         end
      end
   end
   ////////////////////////////////////////////////////////////////
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);
   sequence s_frame_open;
      $fell(select_n);
   endsequence
   sequence s_clock_held;
      serial_port_clock [*3];
   endsequence
   a_clock_idle_high: assert property (select_n |-> serial_port_clock)
      else $error("link clock low while deselected");
   a_first_edge_wait: assert property (s_frame_open |-> s_clock_held)
      else $error("link clock fell too soon after select");
   a_pulse_count: assert property ($rose(select_n) |-> pulses >= 8'h10 && pulses[2:0] == 3'h0)
      else $error("frame pulse count wrong");
   a_host_data_hold: assert property (host_data_oe && serial_port_clock && $past(serial_port_clock)
      |-> $stable(host_data_out))
      else $error("host data moved while link clock high");
   a_dev_data_hold: assert property (dev_data_oe && $past(dev_data_oe) && serial_port_clock
      && $past(serial_port_clock) |-> $stable(dev_data_out))
      else $error("device data moved while link clock high");
   a_no_contention: assert property (!(dev_data_oe && host_data_oe))
      else $error("both ends drive data line");
   a_dev_start_point: assert property ($rose(dev_data_oe) |-> pulses == 8'h08 && is_read && !select_n)
      else $error("device drive began at wrong point");
   a_write_no_drive: assert property (!select_n && pulses != 8'h00 && !is_read |-> !dev_data_oe)
      else $error("device drives during write");
   a_dev_quiet_idle: assert property (select_n [*6] |-> !dev_data_oe)
      else $error("device drives while deselected");
   a_host_release: assert property (is_read && pulses > 8'h08 |-> !host_data_oe)
      else $error("host drives during read data");
endmodule
`default_nettype wire

/* File: tb/spi_slave_sensor_register_access_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module spi_slave_sensor_register_access_bench;
   import spi_sensor_pkg::*;
   localparam byte_t ID_VAL = 8'h3c; // Arbitrary value
   logic CLK = 1'b0;
   logic RST_N = 1'b0;
   logic start = 1'b0;
   logic rd = 1'b0;
   logic auto_inc = 1'b0;
   logic [5:0] addr = 6'h00;
   logic [2:0] byte_count = 3'h1;
   logic [7:0] wbyte = 8'h00;
   logic busy, wtaken, rvalid, done;
   logic [7:0] rbyte;
   byte_t sens [5] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55};
   logic [127:0] calib = 128'hf0e1d2c3b4a5968778695a4b3c2d1e0f;
   byte_t averaging, ctl1, ctl2, ctl3;
   logic [2:0] temp_sel, humid_sel;
   byte_t wq [4] = '{default: 8'h00};
   byte_t rq [4];
   int error_cnt = 0;
   int total_checks = 0;
   always #20 CLK = ~CLK;
   spi_sensor_link link();
   spi_sensor_device #(.IDENTITY_CODE(ID_VAL)) i_spi_sensor_device (.CLK(CLK), .RST_N(RST_N), .LINK(link),
      .HUMID_LOW(sens[1]), .HUMID_HIGH(sens[2]), .TEMP_LOW(sens[3]), .TEMP_HIGH(sens[4]), .MEAS_STATUS(sens[0]),
      .CALIB_INIT(calib), .AVERAGING(averaging), .TEMP_AVERAGE_SELECT(temp_sel),
      .HUMID_AVERAGE_SELECT(humid_sel), .CONTROL_ONE(ctl1), .CONTROL_TWO(ctl2), .CONTROL_THREE(ctl3));
   spi_sensor_host i_spi_sensor_host (.CLK(CLK), .RST_N(RST_N), .LINK(link), .START(start), .READ(rd),
      .AUTO_INC(auto_inc), .ADDR(addr), .BYTE_COUNT(byte_count), .WRITE_BYTE(wbyte), .BUSY(busy),
      .WRITE_TAKEN(wtaken), .READ_BYTE(rbyte), .READ_VALID(rvalid), .DONE(done));
   spi_sensor_props i_spi_sensor_props (.CLK(CLK), .RST_N(RST_N), .select_n(link.select_n),
      .serial_port_clock(link.serial_port_clock), .host_data_out(link.host_data_out),
      .host_data_oe(link.host_data_oe), .dev_data_out(link.dev_data_out), .dev_data_oe(link.dev_data_oe),
      .shared_serial_data(link.shared_serial_data));
   ////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input byte_t e, input byte_t g);
      total_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic xfer(input logic r, input logic inc, input logic [5:0] a, input int n);
      int k;
      int w;
      int got;
      k = 0;
      w = 0;
      got = 0;
      rd = r;
      auto_inc = inc;
      addr = a;
      byte_count = 3'(n);
      wbyte = wq[0];
      start = 1'b1;
      @(posedge CLK);
      #1 start = 1'b0;
      while (done !== 1'b1 && k < 1000) begin
         @(posedge CLK);
         #1 k++;
         if (rvalid === 1'b1 && got < 4) begin
            rq[got] = rbyte;
            got++;
         end
         if (wtaken === 1'b1) begin
            w++;
            wbyte = wq[w % 4];
         end
      end
      chk("read count", r ? 8'(n) : 8'h00, 8'(got));
      chk("frame done", 8'h01, 8'(done));
      repeat (2) @(posedge CLK);
      #1;
      chk("busy", 8'h00, 8'(busy));
   endtask
   task automatic complete_run();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      #(40 * 40000);
      error_cnt++;
      $display("[ERR] watchdog expected done seen hang");
      complete_run();
   end
   initial begin
      repeat (10) @(posedge CLK);
      #1 RST_N = 1'b1;
      xfer(1'b1, 1'b0, 6'h0f, 1);
      chk("identity", ID_VAL, rq[0]);
      xfer(1'b1, 1'b0, 6'h10, 1);
      chk("averaging reset", 8'h1b, rq[0]);
      chk("averaging port", 8'h1b, averaging);
      wq = '{8'h00, 8'h00, 8'h00, 8'h00};
      xfer(1'b0, 1'b0, 6'h0f, 1);
      xfer(1'b1, 1'b0, 6'h0f, 1);
      chk("identity kept", ID_VAL, rq[0]);
      for (int c = 0; c < 8; c++) begin
         wq[0] = {2'b00, 3'(c), 3'(7 - c)};
         xfer(1'b0, 1'b0, 6'h10, 1);
         chk("temp select", 8'(c), {5'h00, temp_sel});
         chk("humid select", 8'(7 - c), {5'h00, humid_sel});
         xfer(1'b1, 1'b0, 6'h10, 1);
         chk("averaging", wq[0], rq[0]);
      end
      wq = '{8'ha5, 8'h3c, 8'h96, 8'h00};
      xfer(1'b0, 1'b1, 6'h20, 3);
      chk("control one", 8'ha5, ctl1);
      chk("control two", 8'h3c, ctl2);
      chk("control three", 8'h96, ctl3);
      xfer(1'b1, 1'b1, 6'h20, 3);
      for (int i = 0; i < 3; i++) chk("control read", wq[i], rq[i]);
      wq = '{8'h5a, 8'h69, 8'h00, 8'h00};
      xfer(1'b0, 1'b0, 6'h21, 2);
      chk("fixed write", 8'h69, ctl2);
      chk("next kept", 8'h96, ctl3);
      xfer(1'b1, 1'b1, 6'h28, 4);
      for (int i = 0; i < 4; i++) chk("output byte", sens[i + 1], rq[i]);
      xfer(1'b1, 1'b0, 6'h28, 3);
      for (int i = 0; i < 3; i++) chk("fixed read", sens[1], rq[i]);
      wq = '{8'hee, 8'h00, 8'h00, 8'h00};
      xfer(1'b0, 1'b0, 6'h2a, 1);
      xfer(1'b1, 1'b0, 6'h2a, 1);
      chk("read-only output", sens[3], rq[0]);
      xfer(1'b1, 1'b0, 6'h27, 1);
      chk("status", sens[0], rq[0]);
      xfer(1'b1, 1'b1, 6'h30, 4);
      for (int i = 0; i < 4; i++) chk("calibration", calib[8 * i +: 8], rq[i]);
      RST_N = 1'b0;
      repeat (2) @(posedge CLK);
      #1 RST_N = 1'b1;
      chk("averaging after reset", 8'h1b, averaging);
      chk("control one after reset", 8'h00, ctl1);
      xfer(1'b1, 1'b0, 6'h2c, 1);
      chk("unmapped", 8'h00, rq[0]);
      complete_run();
   end
endmodule
`default_nettype wire
